// ===== spi_frame_pkg.sv
// Constants for the serial register-access transaction framer.
// Assumes nothing beyond a SystemVerilog compiler.
package spi_frame_pkg;

	// ==========================================
	// Header layout, counted in wire bits
	localparam int HEADER_BITS = 32;
	localparam int ADDR_BITS = 24;
	localparam int LEN_BITS = 6;
	localparam int BYTE_BITS = 8;
	localparam int DIR_POS = 31;
	localparam int RSVD_POS = 30;
	localparam int LEN_MSB = 29;
	localparam int LEN_LSB = 24;
	localparam int WINDOW_MSB = 23;
	localparam int WINDOW_LSB = 16;

	// ==========================================
	// Field values
	localparam logic DIR_READ = 1'b1;
	localparam logic [7:0] DEVICE_WINDOW = 8'hd4;
	localparam logic [4:0] LAST_HEADER_BIT = 5'h1f;
	localparam logic [2:0] LAST_BYTE_BIT = 3'h7;
	localparam logic [2:0] FIRST_BYTE_BIT = 3'h0;

	// ==========================================
	// Sequencing
	typedef enum logic [1:0] {
		FRAME_IDLE,
		FRAME_HEADER,
		FRAME_DATA,
		FRAME_DONE
	} frame_state_type;

endpackage

// ===== pin_sync.sv
// Multi-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes each bit is an independent level; no bus coherence is promised.
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 3,
	parameter int STAGES = 2,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);

	if (STAGES < 2 || WIDTH < 1) begin : bad_params
		$error("pin_sync needs at least two stages and one bit");
	end

	// ==========================================
	// Flop chain; only the last stage is visible
	genvar i;
	generate
		for (i = 0; i < STAGES; i++) begin : chain
			logic [WIDTH-1:0] q;
			logic [WIDTH-1:0] d;
			if (i == 0) begin : head
				assign d = pinIn;
			end else begin : tail
				assign d = chain[i-1].q;
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					q <= RESET_VALUE;
				end else begin
					q <= d;
				end
			end
		end
	endgenerate

	assign pinOut = chain[STAGES-1].q;

endmodule

`default_nettype wire

// ===== spi_register_frame.sv
// Serial register-access transaction framer on the slave side of an SPI link.
// Assumes the SPI clock is slow enough to be oversampled: at least four clk periods per SPI half period.
`timescale 1ns/10ps
`default_nettype none

module spi_register_frame
	import spi_frame_pkg::*;
#(
	parameter int SYNC_STAGES = 2
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic spiClk,
	input wire logic spiCsN,
	input wire logic spiMosi,
	output logic spiMisoOut,
	output logic spiMisoOe,
	output logic headerValid,
	output logic isRead,
	output logic [LEN_BITS-1:0] xferLen,
	output logic [ADDR_BITS-1:0] address,
	output logic [BYTE_BITS-1:0] rxByte,
	output logic rxValid,
	output logic rxLast,
	input wire logic [BYTE_BITS-1:0] txByte,
	output logic txReq,
	output logic frameEnd
);

	// Elaboration-time parameter check
	if (SYNC_STAGES < 2) begin : bad_sync_stages
		$error("spi_register_frame needs at least two synchroniser stages");
	end

	// ==========================================
	// Pin synchronisation and edge detection
	logic [2:0] syncPins;
	logic sclk;
	logic csN;
	logic mosi;
	logic sclkPrev;
	logic csPrev;

	pin_sync #(
		.WIDTH(3),
		.STAGES(SYNC_STAGES),
		.RESET_VALUE(3'h2)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.pinIn({spiClk, spiCsN, spiMosi}),
		.pinOut(syncPins)
	);

	assign sclk = syncPins[2];
	assign csN = syncPins[1];
	assign mosi = syncPins[0];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclkPrev <= 1'b0;
			csPrev <= 1'b1;
		end else begin
			sclkPrev <= sclk;
			csPrev <= csN;
		end
	end

	// Sampling only on rising edges, driving only on falling edges
	wire riseEdge = sclk && !sclkPrev && !csN;
	wire fallEdge = !sclk && sclkPrev && !csN;
	wire csRelease = csN && !csPrev;

	// ==========================================
	// Frame state
	frame_state_type state;
	frame_state_type next_state;
	logic [HEADER_BITS-1:0] header;
	logic [4:0] headerCount;
	logic [2:0] bitInByte;
	logic [LEN_BITS-1:0] byteCount;
	logic [BYTE_BITS-1:0] rxShift;
	logic [BYTE_BITS-1:0] txShift;

	// Header fields as they stand once the last address bit is shifted in
	wire [HEADER_BITS-1:0] fullHeader = {header[HEADER_BITS-2:0], mosi};
	wire hdrRead = fullHeader[DIR_POS] == DIR_READ;
	// fullHeader[RSVD_POS] is deliberately left undecoded
	wire [LEN_BITS-1:0] hdrLen = fullHeader[LEN_MSB:LEN_LSB];
	wire [ADDR_BITS-1:0] hdrAddr = fullHeader[ADDR_BITS-1:0];
	wire hdrMatch = fullHeader[WINDOW_MSB:WINDOW_LSB] == DEVICE_WINDOW;

	wire headerDone = state == FRAME_HEADER && riseEdge && headerCount == LAST_HEADER_BIT;
	wire byteDone = state == FRAME_DATA && riseEdge && bitInByte == LAST_BYTE_BIT;
	wire lastByte = byteCount == xferLen;
	wire [BYTE_BITS-1:0] rxFull = {rxShift[BYTE_BITS-2:0], mosi};
	wire loadTx = state == FRAME_DATA && isRead && fallEdge && bitInByte == FIRST_BYTE_BIT;

	// ==========================================
	// Next-state decode
	always_comb begin
		next_state = state;
		case (state)
			FRAME_IDLE: begin
				if (!csN && csPrev) begin
					next_state = FRAME_HEADER;
				end
			end
			FRAME_HEADER: begin
				if (headerDone) begin
					// Foreign window: sit out the rest of the frame silently
					next_state = hdrMatch ? FRAME_DATA : FRAME_DONE;
				end
			end
			FRAME_DATA: begin
				if (byteDone && lastByte) begin
					next_state = FRAME_DONE;
				end
			end
			FRAME_DONE: begin
				next_state = FRAME_DONE;
			end
			default: begin
				next_state = FRAME_IDLE;
			end
		endcase
		if (csN) begin
			next_state = FRAME_IDLE;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= FRAME_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================
	// Header capture
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			header <= '0;
			headerCount <= '0;
		end else if (state != FRAME_HEADER) begin
			headerCount <= '0;
		end else if (riseEdge) begin
			header <= fullHeader;
			headerCount <= headerCount + 5'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			headerValid <= 1'b0;
			isRead <= 1'b0;
			xferLen <= '0;
			address <= '0;
		end else begin
			headerValid <= headerDone && hdrMatch;
			if (headerDone) begin
				isRead <= hdrRead;
				xferLen <= hdrLen;
				address <= hdrAddr;
			end
		end
	end

	// ==========================================
	// Data phase; any idle gap before the first data bit is simply waited out
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bitInByte <= '0;
			byteCount <= '0;
			rxShift <= '0;
		end else if (state != FRAME_DATA) begin
			bitInByte <= '0;
			byteCount <= '0;
		end else if (riseEdge) begin
			rxShift <= rxFull;
			bitInByte <= bitInByte + 3'h1;
			if (bitInByte == LAST_BYTE_BIT) begin
				byteCount <= byteCount + 6'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxByte <= '0;
			rxValid <= 1'b0;
			rxLast <= 1'b0;
			txReq <= 1'b0;
			frameEnd <= 1'b0;
		end else begin
			rxValid <= byteDone && !isRead;
			rxLast <= byteDone && !isRead && lastByte;
			// Ask for the first read byte after the address, then one after each byte but the last
			txReq <= (headerDone && hdrMatch && hdrRead) || (byteDone && isRead && !lastByte);
			frameEnd <= csRelease;
			if (byteDone && !isRead) begin
				rxByte <= rxFull;
			end
		end
	end

	// ==========================================
	// Read data out, changed only on falling edges
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txShift <= '0;
			spiMisoOut <= 1'b0;
			spiMisoOe <= 1'b0;
		end else begin
			spiMisoOe <= state == FRAME_DATA && isRead && !csN;
			if (loadTx) begin
				txShift <= {txByte[BYTE_BITS-2:0], 1'b0};
				spiMisoOut <= txByte[BYTE_BITS-1];
			end else if (state == FRAME_DATA && isRead && fallEdge) begin
				txShift <= {txShift[BYTE_BITS-2:0], 1'b0};
				spiMisoOut <= txShift[BYTE_BITS-1];
			end
		end
	end

endmodule

`default_nettype wire

// ===== spi_frame_assertions.sv
// Checker on the frame decoder ports.
// Assumes clk oversamples the serial clock.
`timescale 1ns/10ps
`default_nettype none
module spi_frame_assertions
	import spi_frame_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic spiCsN,
	input wire logic spiClk,
	input wire logic spiMisoOut,
	input wire logic spiMisoOe,
	input wire logic headerValid,
	input wire logic isRead,
	input wire logic rxValid,
	input wire logic rxLast,
	input wire logic txReq,
	input wire logic frameEnd,
	input wire logic [ADDR_BITS-1:0] address
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_window; headerValid |-> address[WINDOW_MSB:WINDOW_LSB] == DEVICE_WINDOW; endproperty
	a_window: assert property (p_window) else $error("foreign header");
	property p_oeRead; spiMisoOe |-> isRead; endproperty
	a_oeRead: assert property (p_oeRead) else $error("drive on write");
	property p_oeIdle; spiCsN [*8] |-> !spiMisoOe; endproperty
	a_oeIdle: assert property (p_oeIdle) else $error("drive unselected");
	property p_writeOnly; rxValid |-> !isRead; endproperty
	a_writeOnly: assert property (p_writeOnly) else $error("data on read");
	property p_hdrPulse; headerValid |=> !headerValid; endproperty
	a_hdrPulse: assert property (p_hdrPulse) else $error("long header");
	property p_rxSpacing; rxValid |=> !rxValid [*8]; endproperty
	a_rxSpacing: assert property (p_rxSpacing) else $error("bytes too close");
	property p_txRead; txReq |-> isRead; endproperty
	a_txRead: assert property (p_txRead) else $error("byte asked on write");
	property p_misoHold; spiMisoOe && $past(spiMisoOe) && spiClk |-> $stable(spiMisoOut); endproperty
	a_misoHold: assert property (p_misoHold) else $error("data moved while high");
	c_read: cover property (headerValid && isRead);
	c_last: cover property (rxLast);
	c_end: cover property (frameEnd);
endmodule
bind spi_register_frame spi_frame_assertions chk(.clk, .reset_n, .spiCsN, .spiClk, .spiMisoOut, .spiMisoOe,
	.headerValid, .isRead, .rxValid, .rxLast, .txReq, .frameEnd, .address);
`default_nettype wire

// ===== spi_host_model.sv
// Serial master model, mode 0.
// Assumes one bit spans sixteen clk periods.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
	input wire logic clk,
	input wire logic spiMiso,
	output logic spiClk,
	output logic spiCsN,
	output logic spiMosi
);
	logic [7:0] rd [64];
	initial begin
		spiClk = 1'b0;
		spiCsN = 1'b1;
		spiMosi = 1'b0;
	end
	task automatic half(input int n);
		repeat (8 * n) @(posedge clk);
	endtask
	task automatic shift(input logic b, output logic s);
		spiClk <= 1'b0;
		spiMosi <= b;
		half(1);
		spiClk <= 1'b1;
		s = spiMiso;
		half(1);
	endtask
	task automatic xfer(input logic [31:0] hdr, input int n, input int stall, input logic [7:0] base);
		logic s;
		logic [7:0] d;
		@(posedge clk);
		spiCsN <= 1'b0;
		for (int i = 31; i >= 0; i--) shift(hdr[i], s);
		half(stall);
		for (int k = 0; k < n; k++) begin
			d = base + k[7:0];
			for (int i = 7; i >= 0; i--) shift(d[i], rd[k][i]);
		end
		spiClk <= 1'b0;
		half(1);
		spiCsN <= 1'b1;
		spiMosi <= ~spiMosi;
	endtask
endmodule
`default_nettype wire

// ===== test_spi_register_transaction_frame.sv
// Bench for the frame decoder.
// Assumes spi_host_model drives the pins.
`timescale 1ns/10ps
`default_nettype none
module test_spi_register_transaction_frame;
	import spi_frame_pkg::*;
	logic clk = 1'b0, reset_n = 1'b0, toggle = 1'b0;
	logic [7:0] txByte = 8'h00, txSrc = 8'h00, rxByte, rxq[$];
	logic spiClk, spiCsN, spiMosi, spiMisoOut, spiMisoOe, headerValid, isRead, rxValid, rxLast, txReq, frameEnd;
	logic [5:0] xferLen;
	logic [23:0] address;
	int fails = 0, samples_checked = 0, hdrs = 0, ends = 0, lastAt = 0, oes = 0;
	always #2.5 clk = ~clk;
	spi_host_model host(.clk, .spiMiso(spiMisoOe ? spiMisoOut : toggle), .spiClk, .spiCsN, .spiMosi);
	spi_register_frame dut(.clk, .reset_n, .spiClk, .spiCsN, .spiMosi, .spiMisoOut, .spiMisoOe, .headerValid,
		.isRead, .xferLen, .address, .rxByte, .rxValid, .rxLast, .txByte, .txReq, .frameEnd);
	always @(posedge clk) begin
		toggle <= ~toggle;
		if (rxValid) rxq.push_back(rxByte);
		if (rxLast) lastAt = rxq.size();
		hdrs += headerValid;
		ends += frameEnd;
		oes += spiMisoOe;
		if (txReq) begin
			txByte <= txSrc;
			txSrc <= txSrc + 8'h01;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic frame(input logic [31:0] hdr, input int n, input int stall, input logic [7:0] base);
		rxq.delete();
		hdrs = 0;
		ends = 0;
		lastAt = 0;
		oes = 0;
		host.xfer(hdr, n, stall, base);
		for (int i = 0; i < 20 && ends == 0; i++) @(posedge clk);
		chk(ends, 1);
		if (ends == 0) close_out();
	endtask
	task automatic t_write();
		frame({2'b01, 6'h03, 24'hd4_0010}, 4, 5, 8'ha0);
		chk(hdrs, 1);
		chk(isRead, 0);
		chk(xferLen, 3);
		chk(address, 24'hd4_0010);
		chk(rxq.size(), 4);
		chk(lastAt, 4);
		for (int i = 0; i < 4; i++) chk(rxq[i], 8'ha0 + i);
		$display("write done");
	endtask
	task automatic t_read();
		txSrc = 8'h30;
		frame({2'b10, 6'h3f, 24'hd4_0024}, 64, 0, 8'h00);
		chk(hdrs, 1);
		chk(isRead, 1);
		chk(xferLen, 63);
		chk(address, 24'hd4_0024);
		chk(oes != 0, 1);
		chk(rxq.size(), 0);
		for (int i = 0; i < 64; i++) chk(host.rd[i], 8'h30 + i);
		$display("read done");
	endtask
	task automatic t_abort();
		frame({2'b00, 6'h03, 24'hd4_0040}, 2, 0, 8'h71);
		chk(hdrs, 1);
		chk(rxq.size(), 2);
		chk(lastAt, 0);
		for (int i = 0; i < 2; i++) chk(rxq[i], 8'h71 + i);
		$display("abort done");
	endtask
	task automatic t_foreign();
		frame({2'b00, 6'h00, 24'hd5_0000}, 1, 0, 8'h11);
		chk(hdrs + rxq.size(), 0);
		frame({2'b10, 6'h00, 24'hd5_0024}, 1, 0, 8'h00);
		chk(hdrs, 0);
		chk(oes, 0);
		chk(txSrc, 8'h70);
		frame({2'b00, 6'h00, 24'hd4_00ff}, 1, 0, 8'h5c);
		chk(rxq.size(), 1);
		chk(rxq[0], 8'h5c);
		chk(lastAt, 1);
		$display("window done");
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_write();
		t_read();
		t_abort();
		t_foreign();
		close_out();
	end
endmodule
`default_nettype wire
